//--- pkg/memmap_pkg.sv
// constants, types and field layout shared by the banked memory address map
//
// Contract
// - program fetch and data access use separate ports; fetch served every cycle, data access at most every other cycle
// - 256-byte data EEPROM reached only via its own pointer, never in file map
// - program counter is 13 bits wide, spanning an 8K x 14 space
// - only words 0000h-0FFFh exist; fetch address drops bit 12, aliases wrap
// - reset starts fetch at 0000h; interrupt redirects the counter to 0004h
// - status bits 6 and 5 select data bank 0 to 3
// - each bank holds 128 byte locations, offsets 00h to 7Fh
// - special function registers sit low in every bank, RAM above them
// - core registers, status among them, are mirrored at one offset in all banks
// - any file location is reachable directly or through the pointer register
// - offset 00h has no storage; access acts on the location the pointer names
// - unimplemented locations read zero and keep no written value
// - writable latch holds counter bits 12:8, loaded into the counter on jump
// - indirect address is pointer contents plus a status bit above it
package memmap_pkg;

  localparam int PC_W = 13;
  localparam int PROG_AW = 12;
  localparam int DATA_AW = 9;
  localparam int OFF_W = 7;
  localparam int BYTE_W = 8;
  localparam int LATCH_W = 5;
  localparam int EE_AW = 8;
  localparam int EE_DEPTH = 256;
  localparam int WB_AW = 32;
  localparam int WB_DW = 32;
  localparam int WB_IDX_W = 8;
  localparam int WB_IDX_LSB = 2;
  localparam int WB_PAD_W = WB_DW - BYTE_W;

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  // core register offsets, identical in every bank
  localparam logic [OFF_W-1:0] OFF_INDIRECT = 7'h00;
  localparam logic [OFF_W-1:0] OFF_PC_LOW = 7'h02;
  localparam logic [OFF_W-1:0] OFF_STATUS = 7'h03;
  localparam logic [OFF_W-1:0] OFF_POINTER = 7'h04;
  localparam logic [OFF_W-1:0] OFF_PC_LATCH = 7'h0A;

  // general purpose RAM boundaries within a bank
  localparam logic [OFF_W-1:0] GPR_LO_B0 = 7'h20;
  localparam logic [OFF_W-1:0] GPR_LO_B1 = 7'h20;
  localparam logic [OFF_W-1:0] GPR_LO_B23 = 7'h10;
  localparam logic [OFF_W-1:0] SHARED_LO = 7'h70;
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;

  // status register layout
  localparam int ST_IND_BANK = 7;
  localparam int ST_BANK_HI = 6;
  localparam int ST_BANK_LO = 5;
  localparam logic [BYTE_W-1:0] STATUS_RST = 8'h18;
  localparam logic [BYTE_W-1:0] STATUS_WR_MASK = 8'hE7;
  localparam logic [BYTE_W-1:0] POINTER_RST = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [EE_AW-1:0] EE_PTR_RST = 8'h00;

  // bus word indices outside the 128-entry file window
  localparam logic [WB_IDX_W-1:0] IDX_EE_PTR = 8'h80;
  localparam logic [WB_IDX_W-1:0] IDX_EE_DATA = 8'h81;

  typedef enum logic [2:0] {
    LOC_UNIMPL,
    LOC_INDIRECT,
    LOC_PC_LOW,
    LOC_STATUS,
    LOC_POINTER,
    LOC_PC_LATCH,
    LOC_GPR
  } loc_kind_e;

  typedef struct packed {
    loc_kind_e kind;
    logic [DATA_AW-1:0] phys;
  } loc_decode_s;

endpackage

//--- src/data_addr_decode.sv
// classifies a 9-bit data address and folds shared RAM onto bank 0
`timescale 1ns/1ps
`default_nettype none
module data_addr_decode
  import memmap_pkg::*;
(
  input wire logic [DATA_AW-1:0] i_addr,
  output loc_decode_s o_loc
);

  function automatic loc_decode_s decode_loc(input logic [DATA_AW-1:0] a);
    loc_decode_s r;
    logic [OFF_W-1:0] off;
    logic [1:0] bank;
    off = a[OFF_W-1:0];
    bank = a[DATA_AW-1:OFF_W];
    r.kind = LOC_UNIMPL;
    r.phys = a;
    // core registers first: they win over RAM in every bank
    if (off == OFF_INDIRECT) begin
      r.kind = LOC_INDIRECT;
    end else if (off == OFF_PC_LOW) begin
      r.kind = LOC_PC_LOW;
    end else if (off == OFF_STATUS) begin
      r.kind = LOC_STATUS;
    end else if (off == OFF_POINTER) begin
      r.kind = LOC_POINTER;
    end else if (off == OFF_PC_LATCH) begin
      r.kind = LOC_PC_LATCH;
    end else if (bank == BANK0 && off >= GPR_LO_B0) begin
      r.kind = LOC_GPR;
    end else if (bank != BANK0 && off >= SHARED_LO) begin
      r.kind = LOC_GPR;
      r.phys = {BANK0, off};
    end else if (bank == BANK1 && off >= GPR_LO_B1) begin
      r.kind = LOC_GPR;
    end else if (bank != BANK1 && bank != BANK0 && off >= GPR_LO_B23) begin
      r.kind = LOC_GPR;
    end
    return r;
  endfunction

  assign o_loc = decode_loc(i_addr);

endmodule
`default_nettype wire

//--- src/prog_fetch_unit.sv
// program counter with reset and interrupt vectors and latch-fed jumps
`timescale 1ns/1ps
`default_nettype none
module prog_fetch_unit
  import memmap_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_step,
  input wire logic i_irq,
  input wire logic i_jump_wr,
  input wire logic [BYTE_W-1:0] i_jump_low,
  input wire logic [LATCH_W-1:0] i_latch,
  output logic [PC_W-1:0] o_pc,
  output logic [PROG_AW-1:0] o_prog_addr
);

  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;

  // interrupt beats a same-cycle jump, a jump beats a plain step
  always_comb begin
    pc_next = pc_reg;
    if (i_irq) begin
      pc_next = IRQ_VECTOR;
    end else if (i_jump_wr) begin
      pc_next = {i_latch, i_jump_low};
    end else if (i_step) begin
      pc_next = pc_reg + PC_STEP;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pc_reg <= RESET_VECTOR;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // the fetch address is its own flop so the memory sees no decode path
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_prog_addr <= RESET_VECTOR[PROG_AW-1:0];
    end else begin
      o_prog_addr <= pc_next[PROG_AW-1:0];
    end
  end

  assign o_pc = pc_reg;

endmodule
`default_nettype wire

//--- src/banked_memory_address_map.sv
// banked data memory map, core registers, EEPROM pointer window and fetch counter
`timescale 1ns/1ps
`default_nettype none
module banked_memory_address_map
  import memmap_pkg::*;
#(
  parameter int RAM_DEPTH = 512,
  parameter int EE_SIZE = EE_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [WB_AW-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [WB_DW-1:0] i_wb_dat,
  output logic [WB_DW-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_fetch_step,
  input wire logic i_irq_vector,
  output logic [PROG_AW-1:0] o_prog_addr,
  output logic [PC_W-1:0] o_pc,
  output logic [BYTE_W-1:0] o_status
);

  logic ack_reg;
  logic [WB_DW-1:0] rd_reg;
  logic [BYTE_W-1:0] status_reg;
  logic [BYTE_W-1:0] ptr_reg;
  logic [LATCH_W-1:0] latch_reg;
  logic [EE_AW-1:0] ee_ptr_reg;
  logic [BYTE_W-1:0] ram [RAM_DEPTH];
  logic [BYTE_W-1:0] ee_mem [EE_SIZE];

  logic [WB_IDX_W-1:0] idx;
  logic upper_zero;
  logic file_hit;
  logic ee_ptr_hit;
  logic ee_data_hit;
  logic req_new;
  logic fire_wr;
  logic [DATA_AW-1:0] dir_addr;
  logic [DATA_AW-1:0] ind_addr;
  logic [DATA_AW-1:0] eff_addr;
  logic is_indirect;
  loc_decode_s loc;
  logic [BYTE_W-1:0] wr_byte;
  logic [BYTE_W-1:0] rd_byte;
  logic jump_wr;

  // ---------------- bus decode ----------------
  assign idx = i_wb_adr[WB_IDX_LSB +: WB_IDX_W];
  assign upper_zero = (i_wb_adr[WB_AW-1:WB_IDX_LSB+WB_IDX_W] == '0);
  assign file_hit = upper_zero && !idx[WB_IDX_W-1];
  assign ee_ptr_hit = upper_zero && (idx == IDX_EE_PTR);
  assign ee_data_hit = upper_zero && (idx == IDX_EE_DATA);
  assign req_new = i_wb_cyc && i_wb_stb && !ack_reg;
  // a write lands on the edge where the master sees ack, never earlier
  assign fire_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg && i_wb_sel[0];
  assign wr_byte = i_wb_dat[BYTE_W-1:0];

  // ---------------- address forming ----------------
  assign dir_addr = {status_reg[ST_BANK_HI], status_reg[ST_BANK_LO],
    idx[OFF_W-1:0]};
  assign ind_addr = {status_reg[ST_IND_BANK], ptr_reg};
  assign is_indirect = (idx[OFF_W-1:0] == OFF_INDIRECT);
  assign eff_addr = is_indirect ? ind_addr : dir_addr;

  data_addr_decode u_decode (
    .i_addr(eff_addr),
    .o_loc(loc)
  );

  // ---------------- read mux ----------------
  // a pointer aimed at the indirect port itself reads as an empty location
  always_comb begin
    rd_byte = '0;
    if (file_hit) begin
      case (loc.kind)
        LOC_PC_LOW: rd_byte = o_pc[BYTE_W-1:0];
        LOC_STATUS: rd_byte = status_reg;
        LOC_POINTER: rd_byte = ptr_reg;
        LOC_PC_LATCH: rd_byte = {{(BYTE_W-LATCH_W){1'b0}}, latch_reg};
        LOC_GPR: rd_byte = ram[loc.phys];
        default: rd_byte = '0;
      endcase
    end else if (ee_ptr_hit) begin
      rd_byte = ee_ptr_reg;
    end else if (ee_data_hit) begin
      rd_byte = ee_mem[ee_ptr_reg];
    end
  end

  // ---------------- bus answer ----------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req_new;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_reg <= '0;
    end else if (req_new) begin
      rd_reg <= {{WB_PAD_W{1'b0}}, rd_byte};
    end
  end

  // ---------------- core registers ----------------
  assign jump_wr = fire_wr && file_hit && (loc.kind == LOC_PC_LOW);

  // power-down and timeout flags stay read-only here
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      status_reg <= STATUS_RST;
    end else if (fire_wr && file_hit && loc.kind == LOC_STATUS) begin
      status_reg <= (status_reg & ~STATUS_WR_MASK) | (wr_byte & STATUS_WR_MASK);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ptr_reg <= POINTER_RST;
    end else if (fire_wr && file_hit && loc.kind == LOC_POINTER) begin
      ptr_reg <= wr_byte;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      latch_reg <= LATCH_RST;
    end else if (fire_wr && file_hit && loc.kind == LOC_PC_LATCH) begin
      latch_reg <= wr_byte[LATCH_W-1:0];
    end
  end

  // ---------------- general purpose RAM ----------------
  // only decoded RAM cells take a write, so holes and reserved cells stay empty
  always_ff @(posedge i_ref_clk) begin
    if (fire_wr && file_hit && loc.kind == LOC_GPR) begin
      ram[loc.phys] <= wr_byte;
    end
  end

  // ---------------- EEPROM pointer window ----------------
  // the erase and program sequence is left out; a data write is immediate
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ee_ptr_reg <= EE_PTR_RST;
    end else if (fire_wr && ee_ptr_hit) begin
      ee_ptr_reg <= wr_byte;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (fire_wr && ee_data_hit) begin
      ee_mem[ee_ptr_reg] <= wr_byte;
    end
  end

  // ---------------- program side ----------------
  // fetch port never waits on the data bus, so both move in one cycle
  prog_fetch_unit u_fetch (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_step(i_fetch_step),
    .i_irq(i_irq_vector),
    .i_jump_wr(jump_wr),
    .i_jump_low(wr_byte),
    .i_latch(latch_reg),
    .o_pc(o_pc),
    .o_prog_addr(o_prog_addr)
  );

  assign o_wb_dat = rd_reg;
  assign o_wb_ack = ack_reg;
  assign o_status = status_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_bus_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence

  sequence s_bus_ack;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  property p_bus_answer;
    s_bus_req |=> s_bus_ack;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered in one cycle");

  property p_fetch_parallel;
    i_fetch_step && !i_irq_vector && !jump_wr && fire_wr
      |=> o_pc == $past(o_pc) + PC_STEP;
  endproperty
  a_fetch_parallel: assert property (p_fetch_parallel)
    else $error("fetch stalled by a data access");

  property p_prog_wrap;
    i_fetch_step && !i_irq_vector && !jump_wr && (o_pc[PROG_AW-1:0] == '1)
      |=> o_prog_addr == '0;
  endproperty
  a_prog_wrap: assert property (p_prog_wrap)
    else $error("fetch address did not wrap at 4K");

  property p_reset_vector;
    $fell(i_rst) |-> o_pc == RESET_VECTOR && o_prog_addr == '0;
  endproperty
  a_reset_vector: assert property (@(posedge i_ref_clk) p_reset_vector)
    else $error("counter not at reset vector after reset");

  property p_irq_vector;
    i_irq_vector |=> o_pc == IRQ_VECTOR;
  endproperty
  a_irq_vector: assert property (p_irq_vector)
    else $error("interrupt did not reach vector");

  property p_direct_addr;
    file_hit && !is_indirect
      |-> eff_addr == {o_status[ST_BANK_HI:ST_BANK_LO], i_wb_adr[WB_IDX_LSB +: OFF_W]};
  endproperty
  a_direct_addr: assert property (p_direct_addr)
    else $error("direct address not formed from bank bits");

  property p_indirect_addr;
    file_hit && is_indirect |-> eff_addr == {o_status[ST_IND_BANK], ptr_reg};
  endproperty
  a_indirect_addr: assert property (p_indirect_addr)
    else $error("indirect address not formed from pointer");

  property p_unimpl_zero;
    s_bus_req ##0 (file_hit && (loc.kind == LOC_UNIMPL || loc.kind == LOC_INDIRECT))
      |=> o_wb_ack && o_wb_dat == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented location read nonzero");

  property p_status_mirror;
    s_bus_req ##0 (file_hit && idx[OFF_W-1:0] == OFF_STATUS)
      |=> o_wb_dat[BYTE_W-1:0] == $past(o_status);
  endproperty
  a_status_mirror: assert property (p_status_mirror)
    else $error("status not visible in this bank");

  property p_latch_jump;
    jump_wr && !i_irq_vector |=> o_pc == {$past(latch_reg), $past(wr_byte)};
  endproperty
  a_latch_jump: assert property (p_latch_jump)
    else $error("jump did not take upper bits from latch");

  property p_shared_fold;
    file_hit && loc.kind == LOC_GPR && eff_addr[DATA_AW-1:OFF_W] != BANK0
      && eff_addr[OFF_W-1:0] >= SHARED_LO |-> loc.phys == {BANK0, eff_addr[OFF_W-1:0]};
  endproperty
  a_shared_fold: assert property (p_shared_fold)
    else $error("shared RAM not folded onto bank 0");

  property p_ee_store;
    fire_wr && ee_data_hit |=> ee_mem[$past(ee_ptr_reg)] == $past(wr_byte);
  endproperty
  a_ee_store: assert property (p_ee_store)
    else $error("EEPROM byte not stored at pointer");

  property p_pc_step;
    i_fetch_step && !i_irq_vector && !jump_wr |=> o_pc == $past(o_pc) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("counter did not advance by one");

  // the fetch address is a separate flop, so it could drift from the counter
  property p_fetch_alias;
    o_prog_addr == o_pc[PROG_AW-1:0];
  endproperty
  a_fetch_alias: assert property (p_fetch_alias)
    else $error("fetch address is not the counter without its top bit");

  property p_bank_write;
    fire_wr && file_hit && loc.kind == LOC_STATUS
      |=> o_status[ST_BANK_HI:ST_BANK_LO] == $past(wr_byte[ST_BANK_HI:ST_BANK_LO]);
  endproperty
  a_bank_write: assert property (p_bank_write)
    else $error("bank select bits not taken from the write");

  property p_gpr_store;
    fire_wr && file_hit && loc.kind == LOC_GPR |=> ram[$past(loc.phys)] == $past(wr_byte);
  endproperty
  a_gpr_store: assert property (p_gpr_store)
    else $error("RAM byte not stored at decoded address");

  property p_pointer_write;
    fire_wr && file_hit && loc.kind == LOC_POINTER |=> ptr_reg == $past(wr_byte);
  endproperty
  a_pointer_write: assert property (p_pointer_write)
    else $error("pointer register did not take the write");

  property p_ee_read;
    s_bus_req ##0 ee_data_hit |=> o_wb_dat[BYTE_W-1:0] == ee_mem[$past(ee_ptr_reg)];
  endproperty
  a_ee_read: assert property (p_ee_read)
    else $error("EEPROM read did not return the byte at the pointer");

endmodule
`default_nettype wire

//--- test/core_model.sv
// processor-side model issuing fetch steps and interrupt redirects
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  output logic o_step,
  output logic o_irq
);
  initial begin
    o_step = 1'b0;
    o_irq = 1'b0;
  end
  // one-cycle pulse; fetch runs on its own port, free of data bus traffic
  task automatic pulse(input logic irq);
    @(posedge i_ref_clk);
    while (i_rst) begin
      @(posedge i_ref_clk);
    end
    o_step <= ~irq;
    o_irq <= irq;
    @(posedge i_ref_clk);
    o_step <= 1'b0;
    o_irq <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/tb_banked_memory_address_map.sv
// self-checking bench for the banked memory address map
`timescale 1ns/1ps
`default_nettype none
module tb_banked_memory_address_map
  import memmap_pkg::*;
;
  typedef struct packed {
    logic we;
    logic [7:0] idx;
    logic [7:0] d;
  } row_s;
  logic clk, rst, cyc, stb, we, ack, step, irq;
  logic [WB_AW-1:0] adr;
  logic [3:0] sel;
  logic [WB_DW-1:0] wdat, rdat;
  logic [PROG_AW-1:0] paddr;
  logic [PC_W-1:0] pc;
  logic [BYTE_W-1:0] status, rd;
  int failures, cmp_count;
  row_s rows[] = '{
    '{1'b0, 8'h03, 8'h18},
    '{1'b1, 8'h20, 8'hB0},
    '{1'b1, 8'h70, 8'hC7},
    '{1'b1, 8'h03, 8'h20},
    '{1'b0, 8'h03, 8'h38},
    '{1'b1, 8'h20, 8'hA1},
    '{1'b0, 8'h70, 8'hC7},
    '{1'b1, 8'h03, 8'h40},
    '{1'b1, 8'h10, 8'hD2},
    '{1'b0, 8'h70, 8'hC7},
    '{1'b0, 8'h0F, 8'h00},
    '{1'b1, 8'h03, 8'h60},
    '{1'b1, 8'h10, 8'hE3},
    '{1'b1, 8'h0E, 8'h00},
    '{1'b0, 8'h0E, 8'h00},
    '{1'b1, 8'h05, 8'h55},
    '{1'b0, 8'h05, 8'h00},
    '{1'b0, 8'h10, 8'hE3},
    '{1'b1, 8'h03, 8'h40},
    '{1'b0, 8'h10, 8'hD2},
    '{1'b1, 8'h03, 8'h00},
    '{1'b0, 8'h03, 8'h18},
    '{1'b0, 8'h20, 8'hB0},
    '{1'b1, 8'h04, 8'hA0},
    '{1'b0, 8'h04, 8'hA0},
    '{1'b0, 8'h00, 8'hA1},
    '{1'b1, 8'h00, 8'h5A},
    '{1'b1, 8'h03, 8'h20},
    '{1'b0, 8'h20, 8'h5A},
    '{1'b1, 8'h03, 8'h80},
    '{1'b0, 8'h03, 8'h98},
    '{1'b1, 8'h04, 8'h10},
    '{1'b0, 8'h00, 8'hD2},
    '{1'b1, 8'h04, 8'h00},
    '{1'b0, 8'h00, 8'h00},
    '{1'b1, 8'h03, 8'h00},
    '{1'b1, 8'h0A, 8'hFF},
    '{1'b0, 8'h0A, 8'h1F},
    '{1'b1, 8'h80, 8'h33},
    '{1'b1, 8'h81, 8'h9C},
    '{1'b1, 8'h80, 8'hFF},
    '{1'b1, 8'h81, 8'h77},
    '{1'b1, 8'h80, 8'h33},
    '{1'b0, 8'h81, 8'h9C},
    '{1'b1, 8'h80, 8'hFF},
    '{1'b0, 8'h81, 8'h77}
  };

  banked_memory_address_map dut_u (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_fetch_step(step), .i_irq_vector(irq),
    .o_prog_addr(paddr), .o_pc(pc), .o_status(status));
  core_model core_u (.i_ref_clk(clk), .i_rst(rst), .o_step(step), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then drop for a cycle
  task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] s,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (n >= 64) begin
      failures++;
      $display("BAD t=%0t bus timeout", $time);
      print_verdict();
    end else begin
      rd = rdat[7:0];
      if (!w) chk(rdat[31:8], 0, "upper read bits");
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {22'h0, i, 2'b00}, 4'h1, d);
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, {22'h0, i, 2'b00}, 4'h1, 8'h00);
    chk({24'h0, rd}, {24'h0, e}, $sformatf("read idx %h", i));
  endtask

  task automatic pc_is(input logic [PC_W-1:0] e);
    @(negedge clk);
    chk({19'h0, pc}, {19'h0, e}, "counter");
    chk({20'h0, paddr}, {20'h0, e[PROG_AW-1:0]}, "fetch address");
  endtask

  initial begin
    rst = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = '0;
    sel = 4'h0;
    wdat = '0;
    failures = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk({24'h0, status}, 32'h18, "status at reset");
    pc_is(RESET_VECTOR);
    @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].we) wr(rows[k].idx, rows[k].d);
      else rc(rows[k].idx, rows[k].d);
    end
    // high address bits set must not alias onto the pointer window
    bus(1'b1, 32'h0000_0600, 4'h1, 8'h5A);
    rc(8'h80, 8'hFF);
    bus(1'b0, 32'h0000_0600, 4'h1, 8'h00);
    chk({24'h0, rd}, 32'h0, "unmapped read");
    rc(8'h82, 8'h00);
    bus(1'b1, {22'h0, 8'h20, 2'b00}, 4'h0, 8'h99);
    rc(8'h20, 8'hB0);
    core_u.pulse(1'b0);
    core_u.pulse(1'b0);
    pc_is(13'h0002);
    // the step lands on the very edge at which a data write is acknowledged
    fork
      begin
        @(posedge clk);
        core_u.pulse(1'b0);
      end
      wr(8'h21, 8'h6C);
    join
    pc_is(13'h0003);
    rc(8'h21, 8'h6C);
    rc(8'h20, 8'hB0);
    for (int j = 0; j < 8; j++) begin
      wr(8'h0A, 8'(j * 4));
      wr(8'h02, 8'h20);
      @(posedge clk);
      pc_is({5'(j * 4), 8'h20});
    end
    wr(8'h0A, 8'h0F);
    wr(8'h02, 8'hFF);
    @(posedge clk);
    pc_is(13'h0FFF);
    rc(8'h02, 8'hFF);
    core_u.pulse(1'b0);
    pc_is(13'h1000);
    core_u.pulse(1'b1);
    pc_is(IRQ_VECTOR);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    pc_is(RESET_VECTOR);
    chk({31'h0, ack}, 32'h0, "ack in reset");
    @(posedge clk);
    rst <= 1'b0;
    rc(8'h04, 8'h00);
    rc(8'h0A, 8'h00);
    rc(8'h03, 8'h18);
    pc_is(RESET_VECTOR);
    print_verdict();
  end
endmodule
`default_nettype wire
